// ---- hw/adaptive_backlight_control.v ----
`default_nettype none
`include "backlight_defines.vh"
// Content-adaptive backlight control with Avalon-MM registers
module adaptive_backlight_control #(
   parameter PERIOD_CYC = 416500,
   parameter DIM_STEP = `DIM_STEP_CYC,
   parameter FRAME_PIXELS = 1024
) (
   input wire ref_clk,
   input wire srst,
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire pix_in_valid,
   output wire pix_in_ready,
   input wire [7:0] pix_in_data,
   input wire pix_in_last,
   output reg pix_out_valid,
   input wire pix_out_ready,
   output reg [7:0] pix_out_data,
   output wire brightness_control_line
);
   reg [7:0] display_ctrl_reg;
   reg [7:0] adaptive_ctrl_reg;
   reg [7:0] user_bright_reg;
   reg ack_reg;
   reg [7:0] frame_max_reg;
   reg [7:0] target_reg;
   reg [7:0] gain_reg;
   reg [7:0] current_reg;
   reg [15:0] dim_cnt_reg;
   reg [8:0] pixel_data_reg;
   wire backlight_output_select;
   wire dimming_enable;
   wire [1:0] adaptive_mode;
   wire [7:0] f_data;
   wire f_valid;
   wire f_ready;
   wire [8:0] f_word;
   reg [7:0] target_next;
   reg [7:0] gain_next;
   reg [15:0] scaled;
   wire [15:0] gained;

   assign backlight_output_select = display_ctrl_reg[`BIT_BACKLIGHT_OUTPUT_SELECT];
   assign dimming_enable = display_ctrl_reg[`BIT_DIMMING_ENABLE];
   assign adaptive_mode = {adaptive_ctrl_reg[`BIT_ADAPTIVE_MODE_BIT_HIGH],
      adaptive_ctrl_reg[`BIT_ADAPTIVE_MODE_BIT_LOW]};

   // Map mode to a floor on the backlight, as a fraction of 256
   function [7:0] mode_floor;
      input [1:0] mode;
      begin
         case (mode)
            `MODE_UI: mode_floor = 8'he6;
            `MODE_STILL: mode_floor = 8'hb0;
            `MODE_MOVING: mode_floor = 8'h80;
            default: mode_floor = 8'hff;
         endcase
      end
   endfunction

   // One wait cycle per access keeps the slave simple and the timing fixed
   assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

   // Register writes and the acknowledge cycle
   always @(posedge ref_clk) begin
      if (srst) begin
         ack_reg <= 1'b0;
         display_ctrl_reg <= `RST_DISPLAY_CTRL;
         adaptive_ctrl_reg <= `RST_ADAPTIVE_CTRL;
         user_bright_reg <= `RST_BRIGHTNESS;
      end else begin
         ack_reg <= (avs_read || avs_write) && !ack_reg;
         if (avs_write && ack_reg) begin
            case (avs_address)
               `REG_DISPLAY_CTRL: display_ctrl_reg <= avs_writedata[7:0];
               `REG_ADAPTIVE_CTRL: adaptive_ctrl_reg <= avs_writedata[7:0];
               `REG_BRIGHTNESS: user_bright_reg <= avs_writedata[7:0];
               default: ;
            endcase
         end
      end
   end

   // Read mux; unmapped offsets read as zero
   always @(posedge ref_clk) begin
      if (srst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         case (avs_address)
            `REG_DISPLAY_CTRL: avs_readdata <= {24'h000000, display_ctrl_reg};
            `REG_ADAPTIVE_CTRL: avs_readdata <= {24'h000000, adaptive_ctrl_reg};
            `REG_BRIGHTNESS: avs_readdata <= {24'h000000, user_bright_reg};
            `REG_STATUS: avs_readdata <= {8'h00, gain_reg, target_reg, current_reg};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

   // Pixels queue here so a stalled sink reaches the source
   pixel_fifo #(
      .WIDTH(9),
      .DEPTH(4),
      .AW(2)
   ) u_fifo (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(pix_in_valid),
      .in_ready(pix_in_ready),
      .in_data({pix_in_last, pix_in_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_word)
   );
   assign f_data = f_word[7:0];
   assign f_ready = !pix_out_valid || pix_out_ready;

   // Frame statistic: peak grey level of all pixels but the last; new settings apply from the next frame
   always @* begin
      scaled = 16'h0000;
      target_next = user_bright_reg;
      gain_next = 8'hff;
      if (adaptive_mode != `MODE_OFF) begin
         // Backlight drops to the frame peak but not below the mode floor
         target_next = (frame_max_reg > mode_floor(adaptive_mode)) ?
            frame_max_reg : mode_floor(adaptive_mode);
         // Round up so the UI floor never cuts more than its limit
         scaled = user_bright_reg * target_next + 16'h00ff;
         target_next = scaled[15:8];
         gain_next = (frame_max_reg > mode_floor(adaptive_mode)) ?
            frame_max_reg : mode_floor(adaptive_mode);
      end
   end

   always @(posedge ref_clk) begin
      if (srst) begin
         frame_max_reg <= 8'h00;
         target_reg <= `RST_BRIGHTNESS;
         gain_reg <= 8'hff;
         pixel_data_reg <= 9'h000;
      end else if (f_valid && f_ready) begin
         pixel_data_reg <= f_word;
         if (f_word[8]) begin
            target_reg <= target_next;
            gain_reg <= gain_next;
            frame_max_reg <= 8'h00;
         end else if (f_data > frame_max_reg) begin
            frame_max_reg <= f_data;
         end
      end
   end

   // Grey scale is stretched by the inverse of the backlight cut
   assign gained = (gain_reg == 8'hff) ? {f_data, 8'h00} :
      (({8'h00, f_data} << 8) / {8'h00, gain_reg});

   always @(posedge ref_clk) begin
      if (srst) begin
         pix_out_valid <= 1'b0;
         pix_out_data <= 8'h00;
      end else if (f_ready) begin
         pix_out_valid <= f_valid;
         if (gain_reg == 8'hff || adaptive_mode == `MODE_OFF) begin
            pix_out_data <= f_data;
         end else begin
            pix_out_data <= (gained[15:8] != 8'h00) ? 8'hff : gained[7:0];
         end
      end
   end

   // Dimming: one level per fixed interval in either direction
   always @(posedge ref_clk) begin
      if (srst) begin
         current_reg <= `RST_BRIGHTNESS;
         dim_cnt_reg <= 16'h0000;
      end else if (!dimming_enable) begin
         current_reg <= target_reg;
         dim_cnt_reg <= 16'h0000;
      end else if (dim_cnt_reg >= DIM_STEP - 1) begin
         dim_cnt_reg <= 16'h0000;
         if (current_reg < target_reg) begin
            current_reg <= current_reg + 8'h01;
         end else if (current_reg > target_reg) begin
            current_reg <= current_reg - 8'h01;
         end
      end else begin
         dim_cnt_reg <= dim_cnt_reg + 16'h0001;
      end
   end

   brightness_pwm #(
      .PERIOD_CYC(PERIOD_CYC)
   ) u_pwm (
      .ref_clk(ref_clk),
      .srst(srst),
      .enable(backlight_output_select),
      .level(current_reg),
      .pwm_out(brightness_control_line)
   );
endmodule // adaptive_backlight_control
`default_nettype wire

// ---- hw/backlight_defines.vh ----
`ifndef BACKLIGHT_DEFINES_VH
`define BACKLIGHT_DEFINES_VH
// Register byte addresses
`define REG_DISPLAY_CTRL 4'h0
`define REG_ADAPTIVE_CTRL 4'h4
`define REG_BRIGHTNESS 4'h8
`define REG_STATUS 4'hc
// Field positions
`define BIT_BACKLIGHT_OUTPUT_SELECT 2
`define BIT_DIMMING_ENABLE 3
`define BIT_ADAPTIVE_MODE_BIT_LOW 0
`define BIT_ADAPTIVE_MODE_BIT_HIGH 1
// Mode codes
`define MODE_OFF 2'h0
`define MODE_UI 2'h1
`define MODE_STILL 2'h2
`define MODE_MOVING 2'h3
// Reset values
`define RST_DISPLAY_CTRL 8'h00
`define RST_ADAPTIVE_CTRL 8'h00
`define RST_BRIGHTNESS 8'hff
// Timing: clock in kHz, pulse widths in ns
`define CLK_KHZ 25000
`define PW_MIN_NS 33300
`define PW_MAX_NS 8330000
`define PW_MIN_CYC ((`PW_MIN_NS * (`CLK_KHZ / 1000) + 999) / 1000)
`define PW_MAX_CYC ((`PW_MAX_NS * (`CLK_KHZ / 1000)) / 1000)
// Dimming step interval in cycles
`define DIM_STEP_CYC 256
`endif

// ---- hw/pixel_fifo.v ----
`default_nettype none
// Small synchronous FIFO for pixel words
module pixel_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire ref_clk,
   input wire srst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire push;
   wire pop;

   // Full and empty come straight from the occupancy count
   assign in_ready = (count_reg != DEPTH[AW:0]);
   assign out_valid = (count_reg != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr_reg];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage has no reset; only the pointers and the count need defined values
   always @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Pointer and count update
   always @(posedge ref_clk) begin
      if (srst) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
         end
      end
   end
endmodule // pixel_fifo
`default_nettype wire

// ---- hw/brightness_pwm.v ----
`default_nettype none
`include "backlight_defines.vh"
// PWM of one level per period; widths clamped to the legal window
module brightness_pwm #(
   parameter PERIOD_CYC = 416500
) (
   input wire ref_clk,
   input wire srst,
   input wire enable,
   input wire [7:0] level,
   output reg pwm_out
);
   localparam [31:0] MIN_CYC = `PW_MIN_CYC;
   localparam [31:0] MAX_CYC = `PW_MAX_CYC;
   reg [31:0] cnt_reg;
   reg [31:0] width_reg;
   reg run_reg;
   wire [39:0] prod;
   reg [31:0] width_next;

   assign prod = PERIOD_CYC * level;

   // Width scales with level, then clamped; a zero level holds the line low
   always @* begin
      width_next = prod[39:8];
      if (width_next < MIN_CYC) begin
         width_next = MIN_CYC;
      end
      if (width_next > MAX_CYC) begin
         width_next = MAX_CYC;
      end
      if (level == 8'h00) begin
         width_next = 32'h0000_0000;
      end
   end

   // Width is latched only at period start so a level change never cuts a pulse short
   always @(posedge ref_clk) begin
      if (srst) begin
         cnt_reg <= 32'h0000_0000;
         width_reg <= 32'h0000_0000;
         pwm_out <= 1'b0;
         run_reg <= 1'b0;
      end else begin
         // Output starts only at a period boundary, so enabling mid-period never
         // produces a runt pulse below the minimum width
         if (!enable) begin
            run_reg <= 1'b0;
         end else if (cnt_reg >= PERIOD_CYC - 1) begin
            run_reg <= 1'b1;
         end
         if (cnt_reg >= PERIOD_CYC - 1) begin
            cnt_reg <= 32'h0000_0000;
            width_reg <= width_next;
         end else begin
            cnt_reg <= cnt_reg + 32'h0000_0001;
         end
         pwm_out <= enable && run_reg && (cnt_reg < width_reg);
      end
   end
endmodule // brightness_pwm
`default_nettype wire

// ---- bench/backlight_checker_assertions.sv ----
`default_nettype none
module backlight_checker (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic pix_out_valid,
   input wire logic brightness_control_line
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PW_MIN = 833;
   logic sel_q, sel_d, dd_q;
   logic [1:0] mode_q;
   logic [31:0] hi_cnt;
   wire logic req = avs_read | avs_write;
   wire logic rd_ok = avs_read & ~avs_waitrequest;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Shadow of the control fields; a write only commits once waitrequest is low
   always @(posedge ref_clk) begin
      sel_d <= sel_q;
      if (srst) begin
         {sel_q, dd_q, mode_q} <= 4'h0;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address == 4'h0) {dd_q, sel_q} <= avs_writedata[3:2];
         if (avs_address == 4'h4) mode_q <= avs_writedata[1:0];
      end
   end
   // Length of the running high pulse, sampled when the line falls
   always @(posedge ref_clk) begin
      if (srst || !brightness_control_line) hi_cnt <= 32'h0;
      else hi_cnt <= hi_cnt + 32'h1;
   end
   a_wait_answer: assert property (req && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   a_wait_idle: assert property (!req |-> !avs_waitrequest)
      else $error("waitrequest without request");
   a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
      else $error("access finished in its first cycle");
   a_unmapped_zero: assert property (rd_ok && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_ctrl_back: assert property (rd_ok && avs_address == 4'h0 |-> avs_readdata[3:2] == {dd_q, sel_q})
      else $error("control readback wrong");
   a_mode_back: assert property (rd_ok && avs_address == 4'h4 |-> avs_readdata[1:0] == mode_q)
      else $error("mode readback wrong");
   a_line_quiet: assert property (!sel_q && !sel_d |-> !brightness_control_line)
      else $error("line active with select clear");
   a_pulse_min: assert property ($fell(brightness_control_line) && sel_q |-> hi_cnt >= PW_MIN)
      else $error("pulse too short");
   a_reset_quiet: assert property ($fell(srst) |-> avs_readdata == 32'h0 && !pix_out_valid && !brightness_control_line)
      else $error("outputs busy after reset");
endmodule // backlight_checker
bind adaptive_backlight_control backlight_checker chk_u (.ref_clk(ref_clk), .srst(srst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .pix_out_valid(pix_out_valid),
   .brightness_control_line(brightness_control_line));
`default_nettype wire

// ---- bench/led_driver_model.sv ----
`default_nettype none
module led_driver_model (
   input wire logic ref_clk,
   input wire logic ctrl_line,
   output var logic [31:0] pulse_cnt,
   output var logic [31:0] last_width
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] width_reg;
   initial begin
      pulse_cnt = 32'h0;
      last_width = 32'h0;
      width_reg = 32'h0;
   end
   // LED current follows the line alone; each fall closes one measured pulse
   always @(posedge ref_clk) begin
      if (ctrl_line) begin
         width_reg <= width_reg + 32'h1;
      end else if (width_reg != 32'h0) begin
         last_width <= width_reg;
         pulse_cnt <= pulse_cnt + 32'h1;
         width_reg <= 32'h0;
      end
   end
endmodule // led_driver_model
`default_nettype wire

// ---- bench/adaptive_backlight_control_test.sv ----
`default_nettype none
module adaptive_backlight_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic pix_in_valid = 1'b0;
   logic pix_in_last = 1'b0;
   logic pix_out_ready = 1'b1;
   logic [7:0] pix_in_data = 8'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic avs_waitrequest, pix_in_ready, pix_out_valid, line;
   logic [7:0] pix_out_data;
   logic [31:0] avs_readdata, pulse_cnt, last_width, rd;
   logic [7:0] outq[$];
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   adaptive_backlight_control #(.PERIOD_CYC(1000), .DIM_STEP(4), .FRAME_PIXELS(16)) dut_u (
      .ref_clk(ref_clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pix_in_valid(pix_in_valid),
      .pix_in_ready(pix_in_ready), .pix_in_data(pix_in_data), .pix_in_last(pix_in_last),
      .pix_out_valid(pix_out_valid), .pix_out_ready(pix_out_ready),
      .pix_out_data(pix_out_data), .brightness_control_line(line));
   led_driver_model led_u (.ref_clk(ref_clk), .ctrl_line(line), .pulse_cnt(pulse_cnt),
      .last_width(last_width));
   initial begin
      forever #20 ref_clk = ~ref_clk;
   end
   // Collect delivered pixels; the cycle ceiling cuts a hang short
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (pix_out_valid === 1'b1 && pix_out_ready) outq.push_back(pix_out_data);
      if (cyc == 60000) begin
         error_cnt = error_cnt + 1;
         wrap_up;
      end
   end
   task automatic wrap_up;
      if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Request held until waitrequest is sampled low; read data taken at that edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic frame(input logic [7:0] v);
      @(posedge ref_clk);
      for (int i = 0; i < 16; i++) begin
         pix_in_valid <= 1'b1;
         pix_in_data <= v + 8'(i);
         pix_in_last <= (i == 15);
         do @(posedge ref_clk); while (pix_in_ready !== 1'b1);
      end
      pix_in_valid <= 1'b0;
      pix_in_last <= 1'b0;
   endtask
   task automatic wait_out(input int n);
      for (int k = 0; k < 300 && outq.size() < n; k++) @(posedge ref_clk);
      chk(outq.size() == n, outq.size(), n);
   endtask
   task automatic t_reset;
      bus(0, 4'h0, 0);
      chk(rd === 32'h0, rd, 0);
      bus(0, 4'h4, 0);
      chk(rd === 32'h0, rd, 0);
      bus(0, 4'h8, 0);
      chk(rd[7:0] === 8'hff, rd, 32'hff);
      bus(0, 4'h1, 0);
      chk(rd === 32'h0, rd, 0);
   endtask
   // Stalled sink fills the buffer until it refuses, then drains in order
   task automatic t_fifo;
      pix_out_ready <= 1'b0;
      fork
         frame(8'h10);
      join_none
      repeat (30) @(posedge ref_clk);
      chk(pix_in_ready === 1'b0, pix_in_ready, 0);
      pix_out_ready <= 1'b1;
      wait fork;
      wait_out(16);
      foreach (outq[i]) chk(outq[i] === 8'h10 + 8'(i), outq[i], 8'h10 + i);
      bus(0, 4'hc, 0);
      chk(rd[15:8] === 8'hff, rd, 32'hff);
   endtask
   task automatic t_modes;
      logic [7:0] g0, still_t;
      g0 = rd[23:16];
      for (int m = 1; m < 4; m++) begin
         bus(1, 4'h4, m);
         bus(0, 4'h4, 0);
         chk(rd[1:0] === 2'(m), rd, m);
         outq.delete();
         frame(8'h20);
         frame(8'h20);
         wait_out(32);
         chk(outq[31] > 8'h2f, outq[31], 8'h30);
         bus(0, 4'hc, 0);
         chk(rd[15:8] < 8'hff && rd[23:16] < g0, rd, g0);
         chk(rd[7:0] === rd[15:8], rd, rd[15:8]);
         if (m == 1) chk(rd[15:8] >= 8'he6, rd, 8'he6);
         if (m == 2) chk(rd[15:8] <= 8'hb2, rd, 8'hb2);
         if (m == 3) chk(rd[15:8] <= still_t, rd, still_t);
         still_t = rd[15:8];
      end
   endtask
   task automatic t_pwm;
      logic [31:0] n;
      bus(1, 4'h0, 32'h4);
      n = pulse_cnt;
      repeat (3000) @(posedge ref_clk);
      chk(pulse_cnt > n + 1, pulse_cnt, n + 2);
      chk(last_width === 32'd833, last_width, 833);
      bus(1, 4'h0, 32'h0);
      repeat (5) @(posedge ref_clk);
      n = pulse_cnt;
      repeat (3000) @(posedge ref_clk);
      chk(pulse_cnt === n && line === 1'b0, pulse_cnt, n);
   endtask
   // Level must move by at most one per read and settle on the target
   task automatic ramp(output int len);
      logic [7:0] prev;
      int t0;
      t0 = cyc;
      // Let the frame's last pixel leave the buffer and set the new target
      repeat (4) @(posedge ref_clk);
      bus(0, 4'hc, 0);
      prev = rd[7:0];
      for (int k = 0; k < 400 && rd[7:0] !== rd[15:8]; k++) begin
         bus(0, 4'hc, 0);
         chk(rd[7:0] - prev + 8'h1 <= 8'h2, rd, prev);
         prev = rd[7:0];
      end
      chk(rd[7:0] === rd[15:8], rd, rd[15:8]);
      len = cyc - t0;
   endtask
   task automatic t_dim;
      int up, dn;
      bus(1, 4'h0, 32'h8);
      bus(1, 4'h4, 32'h0);
      frame(8'h20);
      ramp(up);
      bus(1, 4'h4, 32'h3);
      frame(8'h20);
      ramp(dn);
      chk(up > 40 && up - dn < 12 && dn - up < 12, up, dn);
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      t_reset;
      t_fifo;
      t_modes;
      t_pwm;
      t_dim;
      wrap_up;
   end
endmodule // adaptive_backlight_control_test
`default_nettype wire
